// >>> bridge_guard_params.svh
/*
 Constants of the half-bridge protection block: register offsets,
 serial frame bit positions, event bits and protection times.
 Assumes inclusion by bare name from the package and the design.
*/
`ifndef BRIDGE_GUARD_PARAMS_SVH
`define BRIDGE_GUARD_PARAMS_SVH

// APB register byte offsets
`define REG_STATUS 12'h000
`define REG_MASK 12'h004
`define REG_FAULT 12'h008
`define REG_CMD 12'h00C

// Serial frame layout, LSB first on the wire
`define FRAME_BITS 16
`define BIT_LOCKOUT_CTL 15
`define BIT_DELAY_SEL 13
`define BIT_RESET_REQ 0
`define BIT_SUPPLY_FAIL 15
`define BIT_OVERCURRENT 13
`define BIT_SHOOT 12
`define BIT_WARN 0
`define DRV_LSB 1
`define DRV_MSB 6

// Event bits of the status and mask registers
`define EV_FRAME 0
`define EV_SHOOT 1
`define EV_OC 2
`define EV_OV 3
`define EV_WARN 4
`define EV_BITS 5

// Timing: clock rate and protection times in microseconds
`define CLK_MHZ 50
`define OC_LONG_US 200
`define OC_SHORT_US 25
`define FILTER_US 2

// Reset values
`define ZERO32 32'h0000_0000
// Serial pins at rest: clock low, select high, data low
`define LINK_IDLE_PINS 3'h2
`endif

// >>> bridge_guard_pkg.sv
/*
 Types shared by the half-bridge protection block.
 Assumes the constants header sits in the same folder.
*/
`include "bridge_guard_params.svh"

package bridge_guard_pkg;
    // Analog comparator levels arriving from outside the clock domain
    typedef struct packed {
        logic vcc_uv;
        logic load_supply_uv;
        logic load_supply_ov;
        logic [5:0] over_current;
        logic [2:0] thermal_warn;
        logic [2:0] thermal_shut;
    } sense_type;

    // Reported fault flags
    typedef struct packed {
        logic supply_fail_flag;
        logic overcurrent_flag;
        logic shoot_through_flag;
        logic thermal_warning_flag;
    } flags_type;

    // Serial link states, one bit changing per step except LINK_ACCEPT back to LINK_IDLE
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_SHIFT = 2'b01,
        LINK_ACCEPT = 2'b11
    } link_state_type;
endpackage

// >>> bridge_guard.sv
/*
 Protection and output gating of a serially controlled triple half
 bridge: power-up gating, overvoltage lockout, shoot-through check,
 overcurrent shutdown, thermal gating, fault flags, serial slave,
 APB registers with interrupt.
 Assumes sys_clk at 50 MHz, rst_b from the logic-supply power-on
 reset, serial pins and comparators asynchronous to sys_clk.
*/
// Design decisions made here: the APB interface to the registers and the address map.
// Behaviour
// - Drivers off at power-up and during undervoltage
// - Serial logic ignores load supply state
// - Overvoltage sets supply fail flag always
// - Lockout bit: overvoltage forces all outputs off
// - Programmed state kept, restored after overvoltage
// - Supply fail flag cleared only by reset request
// - Both drivers requested: flag, channel off
// - Channel held off until shoot-through flag cleared
// - Sustained overcurrent latches output off, flags
// - Delay select: 200 us or 25 us
// - Reset request re-enables latched output, clears flag
// - Delay timer starts at overcurrent threshold
// - No driver on during thermal shutdown
// - Three warning monitors set warning flag
// - Warning clears only when cool and reset requested
// - Valid frame with reset request bit clears fault status
// - Persisting faults re-set after filter time
`timescale 1ns/100ps
`include "bridge_guard_params.svh"

module bridge_guard
    import bridge_guard_pkg::*;
#(
    parameter int OC_LONG_CYC = `OC_LONG_US * `CLK_MHZ,
    parameter int OC_SHORT_CYC = `OC_SHORT_US * `CLK_MHZ,
    parameter int FILTER_CYC = `FILTER_US * `CLK_MHZ
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic sclk,
    input wire logic chip_select_b,
    input wire logic si,
    output logic so_out,
    output logic so_oe,
    input wire sense_type sense,
    output logic [5:0] drive
);
    localparam int SW = $bits(sense_type);
    localparam logic [13:0] LONG_C = 14'(OC_LONG_CYC);
    localparam logic [13:0] SHORT_C = 14'(OC_SHORT_CYC);
    localparam logic [13:0] FILT_C = 14'(FILTER_CYC);
    localparam logic [4:0] FRAME_C = 5'(`FRAME_BITS);
    // Select idles high, so its synchroniser resets high: no false frame start
    localparam logic [SW+2:0] SYNC_IDLE = {`LINK_IDLE_PINS, {SW{1'b0}}};

    // Two-stage synchronisers for every asynchronous input
    logic [SW+2:0] sync1_reg;
    logic [SW+2:0] sync2_reg;
    sense_type sn;
    logic sclk_s, csb_s, si_s, sclk_d_reg;
    assign {sclk_s, csb_s, si_s} = sync2_reg[SW+2:SW];
    assign sn = sense_type'(sync2_reg[SW-1:0]);

    // Stage one is read only by stage two
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_reg <= SYNC_IDLE;
            sync2_reg <= SYNC_IDLE;
            sclk_d_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            sync1_reg <= {sclk, chip_select_b, si, sense};
            sync2_reg <= sync1_reg;
            sclk_d_reg <= sclk_s;
        end
    end

    // Link edges found from the synchronised serial clock
    wire sclk_rise = sclk_s & ~sclk_d_reg;
    wire sclk_fall = ~sclk_s & sclk_d_reg;

    // Serial slave state
    link_state_type st_reg;
    logic [15:0] shift_reg;
    logic si_bit_reg;
    logic [4:0] cnt_reg;
    logic [15:0] prog_reg;
    flags_type flags_reg;
    logic [5:0] drive_reg;
    logic so_reg, so_oe_reg;
    logic [15:0] out_word;

    // Reply frame: flags and actual driver states
    always_comb
    begin
        out_word = 16'h0000;
        out_word[`BIT_SUPPLY_FAIL] = flags_reg.supply_fail_flag;
        out_word[`BIT_OVERCURRENT] = flags_reg.overcurrent_flag;
        out_word[`BIT_SHOOT] = flags_reg.shoot_through_flag;
        out_word[`BIT_WARN] = flags_reg.thermal_warning_flag;
        out_word[`DRV_MSB:`DRV_LSB] = drive_reg;
    end

    // Serial framing; the load supply never enters here
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg <= LINK_IDLE;
            shift_reg <= 16'h0000;
            si_bit_reg <= 1'b0;
            cnt_reg <= 5'h00;
        end
        else if (clk_en)
        begin
            case (st_reg)
                LINK_IDLE:
                begin
                    // Reply is captured when the select falls
                    if (!csb_s)
                    begin
                        st_reg <= LINK_SHIFT;
                        shift_reg <= out_word;
                        cnt_reg <= 5'h00;
                    end
                end
                LINK_SHIFT:
                begin
                    if (csb_s)
                        st_reg <= (cnt_reg >= FRAME_C) ? LINK_ACCEPT : LINK_IDLE;
                    else if (sclk_rise)
                    begin
                        si_bit_reg <= si_s;
                        // Saturate: longer frames serve a daisy chain
                        if (cnt_reg < FRAME_C)
                            cnt_reg <= cnt_reg + 5'h01;
                    end
                    else if (sclk_fall)
                        shift_reg <= {si_bit_reg, shift_reg[15:1]};
                end
                LINK_ACCEPT:
                    st_reg <= LINK_IDLE;
                default:
                    st_reg <= LINK_IDLE;
            endcase
        end
    end

    // Frame decode at acceptance
    wire accept = (st_reg == LINK_ACCEPT);
    wire reset_req = accept & shift_reg[`BIT_RESET_REQ];
    wire [5:0] req = shift_reg[`DRV_MSB:`DRV_LSB];
    logic [2:0] shoot_hit;
    logic [5:0] shoot_mask;
    logic [2:0] blk_reg;
    logic [5:0] blk6;

    // Per channel shoot-through check and masks
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_chan
            assign shoot_hit[g] = accept & req[2*g] & req[2*g+1];
            assign shoot_mask[2*g+1:2*g] = {2{shoot_hit[g]}};
            assign blk6[2*g+1:2*g] = {2{blk_reg[g]}};
        end
    endgenerate

    // Programmed command, kept through every fault
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prog_reg <= 16'h0000;
            blk_reg <= 3'b000;
        end
        else if (clk_en)
        begin
            if (accept)
            begin
                prog_reg <= shift_reg;
                // Attempted pair is dropped so no later clear arms it
                prog_reg[`DRV_MSB:`DRV_LSB] <= req & ~shoot_mask;
            end
            // New attempt wins over a clear in the same frame
            blk_reg <= shoot_hit | (blk_reg & {3{~reset_req}});
        end
    end

    // Fault filter window after a status clear
    logic [13:0] filt_reg;
    wire filt_done = (filt_reg == 14'h0000);
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            filt_reg <= 14'h0000;
        else if (clk_en)
        begin
            if (reset_req)
                filt_reg <= FILT_C;
            else if (!filt_done)
                filt_reg <= filt_reg - 14'h0001;
        end
    end

    // Overcurrent delay timers, one per output
    logic [13:0] oc_cnt [6];
    logic [5:0] oc_latch_reg;
    logic [5:0] oc_trip;
    wire [13:0] oc_limit = prog_reg[`BIT_DELAY_SEL] ? SHORT_C : LONG_C;
    generate
        for (g = 0; g < 6; g++)
        begin : g_oc
            // Trip on the last cycle of a sustained overcurrent
            assign oc_trip[g] = sense_ok_oc(g) & (oc_cnt[g] == oc_limit - 14'h0001);
            always_ff @(posedge sys_clk or negedge rst_b)
            begin
                if (!rst_b)
                    oc_cnt[g] <= 14'h0000;
                else if (clk_en)
                    // Counts from the threshold crossing; any gap restarts it
                    oc_cnt[g] <= sense_ok_oc(g) ? oc_cnt[g] + 14'h0001 : 14'h0000;
            end
        end
    endgenerate

    // Overcurrent counts only while the output is on and not latched
    function automatic logic sense_ok_oc(input int i);
        sense_ok_oc = sn.over_current[i] & drive_reg[i] & ~oc_latch_reg[i];
    endfunction

    // Latched off until a reset request; a trip wins over a clear
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            oc_latch_reg <= 6'b000000;
        else if (clk_en)
            oc_latch_reg <= oc_trip | (oc_latch_reg & {6{~reset_req}});
    end

    // Fault flag sources
    wire uv = sn.vcc_uv | sn.load_supply_uv;
    wire ov_off = sn.load_supply_ov & prog_reg[`BIT_LOCKOUT_CTL];
    wire tshut_any = |sn.thermal_shut;
    wire twarn_any = |sn.thermal_warn;
    flags_type flags_set;
    assign flags_set.supply_fail_flag = sn.load_supply_ov & filt_done;
    assign flags_set.overcurrent_flag = |oc_trip;
    assign flags_set.shoot_through_flag = |shoot_hit;
    assign flags_set.thermal_warning_flag = twarn_any & filt_done;

    // Flags: set wins; only a reset request clears
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            flags_reg <= '0;
        else if (clk_en)
            flags_reg <= flags_set | (flags_reg & {4{~reset_req}});
    end

    // Output gating; programmed bits return alone when undervoltage, lockout or thermal shutdown go
    wire [5:0] drive_next = prog_reg[`DRV_MSB:`DRV_LSB] & ~oc_latch_reg & ~blk6
        & {6{~uv & ~ov_off & ~tshut_any}};
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            drive_reg <= 6'b000000;
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            drive_reg <= drive_next;
            so_reg <= shift_reg[0];
            so_oe_reg <= ~csb_s & (st_reg != LINK_IDLE);
        end
    end

    // APB decode
    wire setup = psel & ~penable;
    wire access = psel & penable & pready;
    wire hit_st = (paddr == `REG_STATUS);
    wire hit_mk = (paddr == `REG_MASK);
    wire hit_ft = (paddr == `REG_FAULT);
    wire hit_cm = (paddr == `REG_CMD);
    wire mapped = hit_st | hit_mk | hit_ft | hit_cm;
    logic [`EV_BITS-1:0] status_reg, mask_reg, events;
    assign events = {flags_set.thermal_warning_flag & ~flags_reg.thermal_warning_flag,
        sn.load_supply_ov & ~flags_reg.supply_fail_flag, |oc_trip, |shoot_hit, accept};
    wire [`EV_BITS-1:0] w1c = (access & pwrite & hit_st) ? pwdata[`EV_BITS-1:0]
        : {`EV_BITS{1'b0}};
    wire [31:0] rd_mux = hit_st ? 32'(status_reg) : hit_mk ? 32'(mask_reg)
        : hit_ft ? {16'h0000, out_word} : hit_cm ? {16'h0000, prog_reg} : `ZERO32;

    // Registers answer in the first access cycle
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `ZERO32;
            status_reg <= '0;
            mask_reg <= '0;
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            prdata <= setup ? rd_mux : `ZERO32;
            // New events win over a write-one-to-clear
            status_reg <= events | (status_reg & ~w1c);
            if (access & pwrite & hit_mk)
                mask_reg <= pwdata[`EV_BITS-1:0];
            irq <= |(status_reg & mask_reg);
        end
    end

    assign drive = drive_reg;
    assign so_out = so_reg;
    assign so_oe = so_oe_reg;

    // Checks, sampled only on enabled cycles
    default clocking cb @(posedge sys_clk iff clk_en);
    endclocking
    default disable iff (!rst_b);

    uv_off_a: assert property (uv |=> drive_reg == 6'b000000)
        else $error("driver on during undervoltage");
    supply_set_a: assert property (sn.load_supply_ov && filt_done
        |=> flags_reg.supply_fail_flag)
        else $error("overvoltage not flagged");
    lockout_off_a: assert property (ov_off |=> drive_reg == 6'b000000)
        else $error("driver on in overvoltage lockout");
    prog_keep_a: assert property (sn.load_supply_ov && !accept |=> $stable(prog_reg))
        else $error("programmed state lost in overvoltage");
    supply_hold_a: assert property (flags_reg.supply_fail_flag && !reset_req
        |=> flags_reg.supply_fail_flag)
        else $error("supply fail flag dropped");
    shoot_set_a: assert property (|shoot_hit |=> flags_reg.shoot_through_flag
        ##1 (drive_reg & $past(shoot_mask, 2)) == 6'b000000)
        else $error("shoot-through not handled");
    shoot_block_a: assert property (1'b1 |=> (drive_reg & $past(blk6)) == 6'b000000)
        else $error("blocked channel driven");
    // Select bit one must give the short delay, after a run of overcurrent
    oc_delay_a: assert property (oc_trip[0] |-> $past(sn.over_current[0])
        && oc_cnt[0] == (prog_reg[`BIT_DELAY_SEL] ? SHORT_C : LONG_C) - 14'h0001)
        else $error("overcurrent delay wrong");
    // The latch lands one cycle after the trip, the driver one cycle later
    oc_latch_a: assert property (|oc_trip |=> flags_reg.overcurrent_flag
        ##1 (drive_reg & $past(oc_trip, 2)) == 6'b000000)
        else $error("overcurrent trip not latched");
    oc_hold_a: assert property (!reset_req |=> (oc_latch_reg & $past(oc_latch_reg))
        == $past(oc_latch_reg))
        else $error("overcurrent latch lost");
    tshut_off_a: assert property (tshut_any |=> drive_reg == 6'b000000)
        else $error("driver on in thermal shutdown");
    warn_hold_a: assert property (flags_reg.thermal_warning_flag && !reset_req
        |=> flags_reg.thermal_warning_flag)
        else $error("thermal warning dropped");
    reset_clr_a: assert property (reset_req && !(|shoot_hit)
        |=> !flags_reg.shoot_through_flag ##[1:2] filt_reg != 14'h0000)
        else $error("reset request did not clear");

    frame_c: cover property (accept ##1 st_reg == LINK_IDLE);
    shoot_c: cover property (|shoot_hit);
    oc_c: cover property (|oc_trip);
    lockout_c: cover property (ov_off ##1 !ov_off);
endmodule // bridge_guard

// >>> bridge_host_model.sv
/*
 Host model of the serial link of the protection block.
 Assumes the bench calls xfer from one process at a time.
*/
`timescale 1ns/100ps

module bridge_host_model
(
    output logic sclk,
    output logic chip_select_b,
    output logic si,
    input wire logic so_out
);
    // Link idles with select high and clock low
    initial
    begin
        sclk = 1'b0;
        chip_select_b = 1'b1;
        si = 1'b0;
    end

    // One frame of nb bits, LSB first, 160 ns clock, reply sampled on rise
    task automatic xfer(input logic [15:0] cmd, input int nb, output logic [15:0] rep);
        rep = 16'h0000;
        #7.3 chip_select_b = 1'b0;
        #200;
        for (int i = 0; i < nb; i++)
        begin
            si = cmd[i];
            #80 sclk = 1'b1;
            rep[i] = so_out;
            #80 sclk = 1'b0;
        end
        // Clock already low at select rise; released line shows a new level
        #80 chip_select_b = 1'b1;
        si = ~si;
        #400;
    endtask
endmodule // bridge_host_model

// >>> half_bridge_fault_protection_test.sv
/*
 Self-checking bench of the protection block with a serial host model.
 Assumes the design package and constants header in the same folder.
*/
`timescale 1ns/100ps
`include "bridge_guard_params.svh"

module half_bridge_fault_protection_test
    import bridge_guard_pkg::*;
;
    localparam int OC_S = 10; // Shortened trip delays keep the run brief
    localparam int OC_L = 40;
    logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, e;
    logic sclk, chip_select_b, si, so_out, so_oe, clk_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    sense_type sense;
    logic [5:0] drive;
    logic [15:0] rep, cmd, prev;
    int err_count, cmp_count, cyc;
    int seed = 32'h012bc244;

    bridge_guard #(.OC_LONG_CYC(OC_L), .OC_SHORT_CYC(OC_S), .FILTER_CYC(4)) u_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .sclk(sclk), .chip_select_b(chip_select_b),
        .si(si), .so_out(so_out), .so_oe(so_oe), .sense(sense), .drive(drive));
    bridge_host_model u_host (.sclk(sclk), .chip_select_b(chip_select_b), .si(si),
        .so_out(so_out));

    // 50 MHz clock
    initial sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;

    // Hang guard: far above the length of the sequence
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            err_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // APB transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        // No assumed latency: only the hang guard ends this wait
        do
        begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        // Answer taken at the same edge, then the request is released
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Frame, then let the accept and driver update land
    task automatic fr(input logic [15:0] c);
        u_host.xfer(c, 16, rep);
        wc(3);
    endtask

    // Never request both drivers of one pair
    function automatic logic [15:0] legal(input logic [15:0] c);
        for (int k = 0; k < 3; k++)
            if (c[2 * k + 1] && c[2 * k + 2])
                c[2 * k + 2] = 1'b0;
        return c & 16'hA07E;
    endfunction

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, sense, cyc, err_count, cmp_count} = '0;
        rst_b = 1'b0;
        clk_en = 1'b1;
        wc(20);
        rst_b <= 1'b1;
        wc(5);
        check(drive, 6'h00);
        check(so_oe, 1'b0);
        apb(1'b0, `REG_MASK, 32'h0000_0000);
        check(rd, `ZERO32);
        apb(1'b0, 12'h010, 32'h0000_0000);
        check(rd, `ZERO32);
        check(e, 1'b1);
        // Random legal commands; each reply reports the previous drive
        prev = 16'h0000;
        for (int i = 0; i < 8; i++)
        begin
            cmd = legal(16'($random(seed)));
            fr(cmd);
            check(rep, {9'h000, prev[6:1], 1'b0});
            check(drive, cmd[6:1]);
            prev = cmd;
        end
        // Frame-accepted event, masked into the interrupt and cleared
        apb(1'b1, `REG_MASK, 32'h0000_0001);
        wc(2);
        check(irq, 1'b1);
        apb(1'b1, `REG_STATUS, 32'h0000_0001);
        wc(2);
        check(irq, 1'b0);
        // Load undervoltage: serial logic still works, drivers stay off
        sense.load_supply_uv <= 1'b1;
        fr(16'h0008);
        check(drive, 6'h00);
        apb(1'b0, `REG_CMD, 32'h0000_0000);
        check(rd, 32'h0000_0008);
        sense.load_supply_uv <= 1'b0;
        wc(6);
        check(drive, 6'h04);
        // Overvoltage with lockout off, then on, then recovery
        sense.load_supply_ov <= 1'b1;
        wc(10);
        fr(16'h0004);
        check(drive, 6'h02);
        fr(16'h8004);
        check(rep[15], 1'b1);
        check(drive, 6'h00);
        sense.load_supply_ov <= 1'b0;
        wc(10);
        check(drive, 6'h02);
        fr(16'h0005);
        check(rep[15], 1'b1);
        fr(16'h0004);
        check(rep[15], 1'b0);
        // Shoot-through attempt on pair one
        fr(16'h0006);
        check(drive, 6'h00);
        fr(16'h0004);
        check({rep[12], drive}, {1'b1, 6'h00});
        fr(16'h0005);
        fr(16'h0004);
        check({rep[12], drive}, {1'b0, 6'h02});
        // Overcurrent trip, short delay, latched until reset request
        fr(16'h2002);
        sense.over_current[0] <= 1'b1;
        wc(OC_S + 8);
        check(drive, 6'h00);
        sense.over_current[0] <= 1'b0;
        fr(16'h2002);
        check({rep[13], drive}, {1'b1, 6'h00});
        fr(16'h2003);
        check(drive, 6'h01);
        // Long delay chosen first: still on past the short time, off after the long
        fr(16'h0002);
        sense.over_current[0] <= 1'b1;
        wc(OC_S + 8);
        check(drive, 6'h01);
        wc(OC_L);
        check(drive, 6'h00);
        sense.over_current[0] <= 1'b0;
        fr(16'h0003);
        // Thermal shutdown blocks turn-on
        sense.thermal_shut[1] <= 1'b1;
        fr(16'h0010);
        check(drive, 6'h00);
        sense.thermal_shut[1] <= 1'b0;
        // Thermal warning: sticky while hot, reset only after cooling
        sense.thermal_warn[2] <= 1'b1;
        wc(10);
        fr(16'h0011);
        wc(10);
        fr(16'h0010);
        check({rep[0], drive}, {1'b1, 6'h08});
        sense.thermal_warn[2] <= 1'b0;
        wc(10);
        fr(16'h0010);
        check(rep[0], 1'b1);
        fr(16'h0011);
        fr(16'h0010);
        check(rep[0], 1'b0);
        // Short frame is ignored
        u_host.xfer(16'h0002, 8, rep);
        wc(3);
        check(drive, 6'h08);
        // Clock enable low freezes the gating while the logic supply drops
        clk_en <= 1'b0;
        sense.vcc_uv <= 1'b1;
        wc(8);
        check(drive, 6'h08);
        clk_en <= 1'b1;
        wc(6);
        check(drive, 6'h00);
        sense.vcc_uv <= 1'b0;
        wc(6);
        check(drive, 6'h08);
        // Reset in mid-run: drivers and the stored command fall back to off
        rst_b <= 1'b0;
        wc(2);
        check(drive, 6'h00);
        rst_b <= 1'b1;
        wc(5);
        apb(1'b0, `REG_CMD, 32'h0000_0000);
        check(rd, `ZERO32);
        check(drive, 6'h00);
        give_verdict();
    end
endmodule // half_bridge_fault_protection_test
